// >>> src/spi_errata_behaviour.sv
`timescale 1ns/1ps
`include "spi_errata_regs.svh"

module spi_errata_behaviour (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic                          enable,
   input  wire logic                          target_mode,
   input  wire logic                          soft_reset_bit,
   input  wire logic                          mode_fault_disable,
   input  wire logic [1:0]                    cs_select,
   input  wire spi_errata_pkg::cs_config_t    cs_config [`NUM_CS],
   input  wire logic                          tx_write,
   input  wire logic [`DATA_W-1:0]            tx_wdata,
   input  wire logic                          rx_read,
   input  wire logic                          miso,
   input  wire logic                          target_sck,
   input  wire logic                          target_cs_n,
   input  wire logic                          target_mosi,
   output logic                               tx_empty_flag,
   output logic                               tx_lost_pulse,
   output logic                               rx_full_flag,
   output logic [`DATA_W-1:0]                 rx_data,
   output logic                               sck,
   output logic                               mosi,
   output logic [`NUM_CS-1:0]                 cs_n,
   output logic                               target_miso,
   output logic                               busy
);
   // ==========================================
   // Declarations
   spi_errata_pkg::xfer_state_t state_reg, state_next;
   spi_errata_pkg::word_t       tx_data_reg, tx_data_next;
   logic [`DATA_W-1:0]          shift_reg, shift_next;
   logic [`DATA_W-1:0]          rx_reg, rx_next;
   logic [`BITS_W-1:0]          bits_reg, bits_next;
   logic                        empty_reg, empty_next;
   logic                        rxf_reg, rxf_next;
   logic                        lost_reg, lost_next;
   logic                        sck_reg, sck_next;
   logic                        phase_reg, phase_next;
   logic [`NUM_CS-1:0]          cs_reg, cs_next;
   logic [1:0]                  cur_cs_reg, cur_cs_next;
   logic                        prev_one_reg, prev_one_next;
   logic                        glitch_reg, glitch_next;
   logic                        tsck_reg, tsck_next;
   logic                        active;
   logic                        blocked;
   logic                        tick;
   logic                        t_rise;
   spi_errata_pkg::cs_config_t  cfg;

   // ==========================================
   // Derived conditions
   assign active  = enable | target_mode;
   assign blocked = cs_config[0].cs_hold_after_transfer & ~mode_fault_disable;
   assign cfg     = cs_config[cur_cs_reg];
   assign t_rise  = target_mode & ~target_cs_n & target_sck & ~tsck_reg;

   clock_divider_tick u_div (
      .clk     (clk),
      .reset   (reset),
      .run     (state_reg == spi_errata_pkg::ST_SHIFT),
      .divider (cfg.serial_clock_divider),
      .tick    (tick)
   );

   // ==========================================
   // Next state
   always_comb begin
      state_next    = state_reg;
      tx_data_next  = tx_data_reg;
      shift_next    = shift_reg;
      rx_next       = rx_reg;
      bits_next     = bits_reg;
      empty_next    = empty_reg;
      rxf_next      = rxf_reg;
      lost_next     = 1'b0;
      sck_next      = sck_reg;
      phase_next    = phase_reg;
      cs_next       = cs_reg;
      cur_cs_next   = cur_cs_reg;
      prev_one_next = prev_one_reg;
      glitch_next   = 1'b0;
      tsck_next     = target_sck;

      if (rx_read) begin
         rxf_next = 1'b0;
      end

      if (tx_write) begin
         if (active) begin
            tx_data_next = '{valid: 1'b1, data: tx_wdata};
            empty_next   = 1'b0;
         end else begin
            lost_next = 1'b1;
         end
      end

      if (target_mode) begin
         if (t_rise) begin
            rx_next   = {rx_reg[`DATA_W-2:0], target_mosi};
            shift_next = {shift_reg[`DATA_W-2:0], 1'b0};
            bits_next = bits_reg + `BITS_W'(1);
            if (bits_reg == `BITS_W'(`DATA_W - 1)) begin
               bits_next = '0;
               rxf_next  = 1'b1;
               if (tx_data_reg.valid) begin
                  shift_next   = tx_data_reg.data;
                  // Same-cycle write stays pending
                  if (!tx_write) begin
                     tx_data_next = '{valid: 1'b0, data: tx_data_reg.data};
                     empty_next   = 1'b1;
                  end
               end
            end
         end
      end else begin
         case (state_reg)
            spi_errata_pkg::ST_IDLE: begin
               sck_next = cfg.clock_polarity_bit;
               if (tx_data_reg.valid && active && !blocked) begin
                  cur_cs_next  = cs_select;
                  shift_next   = tx_data_reg.data;
                  // Same-cycle write stays pending
                  if (!tx_write) begin
                     tx_data_next = '{valid: 1'b0, data: tx_data_reg.data};
                     empty_next   = 1'b1;
                  end
                  bits_next    = '0;
                  phase_next   = 1'b0;
                  state_next   = spi_errata_pkg::ST_LEAD;
               end
            end
            spi_errata_pkg::ST_LEAD: begin
               cs_next  = ~(`NUM_CS'(1) << cur_cs_reg);
               sck_next = cfg.clock_polarity_bit;
               // Divider changed to or from 1, idle-high, phase 0
               if (cfg.clock_polarity_bit && !cfg.clock_phase_bit &&
                   (prev_one_reg != (cfg.serial_clock_divider <= `DIV_ONE))) begin
                  glitch_next = 1'b1;
               end
               prev_one_next = (cfg.serial_clock_divider <= `DIV_ONE);
               state_next    = spi_errata_pkg::ST_SHIFT;
            end
            spi_errata_pkg::ST_SHIFT: begin
               // Extra pulse takes the place of a tick
               if (tick && !glitch_reg) begin
                  sck_next   = ~sck_reg;
                  phase_next = ~phase_reg;
                  if (phase_reg == cfg.clock_phase_bit) begin
                     rx_next = {rx_reg[`DATA_W-2:0], miso};
                  end else if (phase_reg || bits_reg != '0) begin
                     // First bit already stands on the line
                     shift_next = {shift_reg[`DATA_W-2:0], 1'b0};
                  end
                  if (phase_reg) begin
                     bits_next = bits_reg + `BITS_W'(1);
                     if (bits_reg == `BITS_W'(`DATA_W - 1)) begin
                        bits_next  = '0;
                        rxf_next   = 1'b1;
                        state_next = spi_errata_pkg::ST_HOLD;
                     end
                  end
               end
            end
            spi_errata_pkg::ST_HOLD: begin
               sck_next = cfg.clock_polarity_bit;
               if (!cfg.cs_hold_after_transfer) begin
                  cs_next = '1;
               end
               state_next = spi_errata_pkg::ST_IDLE;
            end
            default: state_next = spi_errata_pkg::ST_IDLE;
         endcase
      end
      if (glitch_reg) begin
         sck_next = ~sck_reg;
      end
   end

   // ==========================================
   // Registers
   always_ff @(posedge clk) begin
      if (reset || soft_reset_bit) begin
         state_reg    <= spi_errata_pkg::ST_IDLE;
         tx_data_reg  <= '0;
         shift_reg    <= '0;
         rx_reg       <= '0;
         bits_reg     <= '0;
         empty_reg    <= 1'b1;
         rxf_reg      <= 1'b0;
         lost_reg     <= 1'b0;
         sck_reg      <= 1'b0;
         phase_reg    <= 1'b0;
         cs_reg       <= '1;
         cur_cs_reg   <= '0;
         prev_one_reg <= 1'b0;
         glitch_reg   <= 1'b0;
         tsck_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         tx_data_reg  <= tx_data_next;
         shift_reg    <= shift_next;
         rx_reg       <= rx_next;
         bits_reg     <= bits_next;
         empty_reg    <= empty_next;
         rxf_reg      <= rxf_next;
         lost_reg     <= lost_next;
         sck_reg      <= sck_next;
         phase_reg    <= phase_next;
         cs_reg       <= cs_next;
         cur_cs_reg   <= cur_cs_next;
         prev_one_reg <= prev_one_next;
         glitch_reg   <= glitch_next;
         tsck_reg     <= tsck_next;
      end
   end

   assign tx_empty_flag = empty_reg;
   assign tx_lost_pulse = lost_reg;
   assign rx_full_flag  = rxf_reg;
   assign rx_data       = rx_reg;
   assign sck           = sck_reg;
   assign mosi          = shift_reg[`DATA_W-1];
   assign cs_n          = cs_reg;
   assign target_miso   = shift_reg[`DATA_W-1];
   assign busy          = (state_reg != spi_errata_pkg::ST_IDLE);
endmodule

// >>> src/spi_errata_regs.svh
`ifndef SPI_ERRATA_REGS_SVH
`define SPI_ERRATA_REGS_SVH

`define DIV_W        8
`define DATA_W       16
`define NUM_CS       4
`define DIV_ONE      8'h01
`define DIV_RESET    8'h02
`define BITS_W       5
`define BITS_RESET   5'h08

`endif

// >>> src/spi_errata_pkg.sv
package spi_errata_pkg;

   typedef struct packed {
      logic       clock_polarity_bit;
      logic       clock_phase_bit;
      logic       cs_hold_after_transfer;
      logic [7:0] serial_clock_divider;
   } cs_config_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } word_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_LEAD  = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_HOLD  = 4'b1000
   } xfer_state_t;

endpackage

// >>> src/clock_divider_tick.sv
`timescale 1ns/1ps
`include "spi_errata_regs.svh"

// ==========================================
// Half-period tick generator
module clock_divider_tick (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire logic                run,
   input  wire logic [`DIV_W-1:0]   divider,
   output logic                     tick
);
   logic [`DIV_W-1:0] count_reg;
   logic [`DIV_W-1:0] count_next;

   always_comb begin
      count_next = count_reg;
      tick       = 1'b0;
      if (!run) begin
         count_next = '0;
      end else if (count_reg + `DIV_W'(1) >= divider) begin
         count_next = '0;
         tick       = 1'b1;
      end else begin
         count_next = count_reg + `DIV_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule

// >>> tb/spi_errata_behaviour_asserts.sv
`timescale 1ns/1ps
`include "spi_errata_regs.svh"
module spi_errata_behaviour_asserts (
   input wire logic                       clk,
   input wire logic                       reset,
   input wire logic                       soft_reset_bit,
   input wire logic                       enable,
   input wire logic                       target_mode,
   input wire logic                       mode_fault_disable,
   input wire logic [1:0]                 cs_select,
   input wire spi_errata_pkg::cs_config_t cs_config [`NUM_CS],
   input wire logic                       tx_write,
   input wire logic                       tx_empty_flag,
   input wire logic                       tx_lost_pulse,
   input wire logic                       sck,
   input wire logic                       busy
);
   // ====================
   // Transfer shape tracking
   spi_errata_pkg::cs_config_t cfg;
   logic                       drop, blocked, div1;
   logic [5:0]                 tog_reg;
   logic                       extra_reg, prev1_reg, pol_reg, seen_reg, busy_reg, sck_reg, chk_reg;
   assign cfg     = cs_config[cs_select];
   assign div1    = cfg.serial_clock_divider <= 8'h01;
   assign drop    = tx_write & ~enable & ~target_mode;
   assign blocked = cs_config[0].cs_hold_after_transfer & ~mode_fault_disable & ~target_mode;
   always_ff @(posedge clk) begin
      busy_reg <= busy;
      sck_reg  <= sck;
      if (reset || soft_reset_bit) begin
         seen_reg <= 1'h0;
         tog_reg  <= 6'h00;
      end else if (busy && !busy_reg) begin
         // Only compare against a previous transfer of the same polarity
         chk_reg   <= seen_reg && (cfg.clock_polarity_bit == pol_reg);
         extra_reg <= cfg.clock_polarity_bit & ~cfg.clock_phase_bit & (div1 != prev1_reg);
         prev1_reg <= div1;
         pol_reg   <= cfg.clock_polarity_bit;
         seen_reg  <= 1'h1;
         tog_reg   <= 6'h00;
      end else if (busy && sck != sck_reg) begin
         tog_reg <= tog_reg + 6'h01;
      end
   end
   // ====================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (reset || soft_reset_bit);
   hold_blocks_start_a: assert property (blocked && !busy |=> !busy)
      else $error("Transfer started with hold and mode fault on");
   target_keeps_on_a: assert property (target_mode && !enable && tx_write |=> !tx_lost_pulse ##1 !tx_lost_pulse)
      else $error("Target write dropped while disabled");
   drop_keeps_empty_a: assert property (drop && !busy |=> $stable(tx_empty_flag) && tx_lost_pulse)
      else $error("Dropped write changed empty flag or gave no loss pulse");
   write_taken_a: assert property (tx_write && (enable || target_mode) |=> !tx_empty_flag)
      else $error("Accepted write left empty flag high");
   lost_has_cause_a: assert property (tx_lost_pulse |-> $past(drop))
      else $error("Loss pulse without a dropped write");
   extra_pulse_a: assert property ($fell(busy) && chk_reg |-> tog_reg == 6'h20 + {5'h00, extra_reg})
      else $error("Clock edge count wrong for divider mix");
   cover property (blocked && tx_write);
   cover property (drop);
   cover property ($fell(busy) && chk_reg && extra_reg);
endmodule

// >>> tb/spi_peer_model.sv
`timescale 1ns/1ps
module spi_peer_model (
   input  wire logic        sck,
   input  wire logic [3:0]  cs_n,
   input  wire logic        mosi,
   input  wire logic        pol,
   input  wire logic        pha,
   input  wire logic [15:0] tx_word,
   output logic             miso,
   output logic [15:0]      rx_word
);
   // ====================
   // Shift on the edges of the selected mode
   logic [15:0] shift;
   logic        sel;
   logic        edge_seen;
   assign sel = ~&cs_n;
   initial miso = 1'h0;
   always @(posedge sel) begin
      shift     = tx_word;
      miso      = shift[15];
      edge_seen = 1'h0;
   end
   // Released line shows the inverse of the last bit
   always @(negedge sel) miso = ~miso;
   always @(sck) begin
      if (sel && ((sck ^ pol) != pha)) begin
         rx_word = {rx_word[14:0], mosi};
      end else if (sel && edge_seen) begin
         // First edge of a frame never shifts
         shift = {shift[14:0], 1'h0};
         miso  = shift[15];
      end
      if (sel) edge_seen = 1'h1;
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "spi_errata_regs.svh"
module tb_top;
   // ====================
   // Stimulus and wiring
   logic                       clk = 1'h0;
   logic                       reset = 1'h1;
   logic                       enable = 1'h1;
   logic                       target_mode = 1'h0;
   logic                       soft_reset_bit = 1'h0;
   logic                       mode_fault_disable = 1'h1;
   logic [1:0]                 cs_select = 2'h0;
   spi_errata_pkg::cs_config_t cs_config [`NUM_CS] = '{default: '{1'h0, 1'h1, 1'h0, 8'h01}};
   logic                       tx_write = 1'h0;
   logic [15:0]                tx_wdata = 16'h0000;
   logic                       rx_read = 1'h0;
   logic                       target_sck = 1'h0;
   logic                       target_cs_n = 1'h1;
   logic                       target_mosi = 1'h0;
   logic                       miso, tx_empty_flag, tx_lost_pulse, rx_full_flag, sck, mosi, busy, target_miso;
   logic [15:0]                rx_data, peer_rx;
   logic [3:0]                 cs_n;
   int                         err_count = 0;
   int                         cmp_count = 0;
   int                         lost_cnt = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (tx_lost_pulse === 1'h1) lost_cnt++;
   spi_errata_behaviour dut (.clk, .reset, .enable, .target_mode, .soft_reset_bit, .mode_fault_disable,
      .cs_select, .cs_config, .tx_write, .tx_wdata, .rx_read, .miso, .target_sck, .target_cs_n,
      .target_mosi, .tx_empty_flag, .tx_lost_pulse, .rx_full_flag, .rx_data, .sck, .mosi, .cs_n,
      .target_miso, .busy);
   spi_peer_model peer (.sck, .cs_n, .mosi, .pol(cs_config[cs_select].clock_polarity_bit),
      .pha(cs_config[cs_select].clock_phase_bit), .tx_word(16'h3C5A), .miso, .rx_word(peer_rx));
   // ====================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic write_word(input logic [15:0] d);
      @(negedge clk);
      tx_write = 1'h1;
      tx_wdata = d;
      @(negedge clk);
      tx_write = 1'h0;
   endtask
   task automatic wait_xfer;
      int n;
      n = 0;
      while (busy !== 1'h1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk(busy, 16'h0001);
      while (busy !== 1'h0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk(busy, 16'h0000);
      chk(rx_full_flag, 16'h0001);
      rx_read = 1'h1;
      @(negedge clk);
      rx_read = 1'h0;
   endtask
   task automatic tgt_frame(input logic [15:0] d);
      target_cs_n = 1'h0;
      for (int i = 15; i >= 0; i--) begin
         target_mosi = d[i];
         repeat (3) @(negedge clk);
         target_sck = 1'h1;
         repeat (3) @(negedge clk);
         target_sck = 1'h0;
      end
      repeat (3) @(negedge clk);
      target_cs_n = 1'h1;
      repeat (3) @(negedge clk);
   endtask
   // ====================
   // Sequence
   initial begin
      repeat (10) @(negedge clk);
      reset = 1'h0;
      chk(tx_empty_flag, 16'h0001);
      chk(cs_n, 16'h000F);
      write_word(16'hA5C3);
      wait_xfer();
      chk(rx_data, 16'h3C5A);
      chk(peer_rx, 16'hA5C3);
      cs_config[0].cs_hold_after_transfer = 1'h1;
      mode_fault_disable = 1'h0;
      write_word(16'h0F0F);
      repeat (100) @(negedge clk);
      chk(busy, 16'h0000);
      chk(tx_empty_flag, 16'h0000);
      mode_fault_disable = 1'h1;
      wait_xfer();
      repeat (2) @(negedge clk);
      enable = 1'h0;
      tx_write = 1'h1;
      for (int i = 0; i < 3; i++) begin
         tx_wdata = 16'h1000 | 16'(i);
         @(negedge clk);
      end
      tx_write = 1'h0;
      repeat (3) @(negedge clk);
      chk(16'(lost_cnt), 16'h0003);
      chk(tx_empty_flag, 16'h0001);
      enable = 1'h1;
      write_word(16'h2222);
      wait_xfer();
      target_mode = 1'h1;
      enable = 1'h0;
      write_word(16'h5AA5);
      chk(tx_empty_flag, 16'h0000);
      chk(16'(lost_cnt), 16'h0003);
      tgt_frame(16'hC33C);
      chk(rx_full_flag, 16'h0001);
      chk(rx_data, 16'hC33C);
      chk(tx_empty_flag, 16'h0001);
      chk(target_miso, 16'h0000);
      rx_read = 1'h1;
      @(negedge clk);
      rx_read = 1'h0;
      soft_reset_bit = 1'h1;
      @(negedge clk);
      soft_reset_bit = 1'h0;
      chk(rx_full_flag, 16'h0000);
      chk(rx_data, 16'h0000);
      chk(tx_empty_flag, 16'h0001);
      target_mode = 1'h0;
      enable = 1'h1;
      cs_config[0] = '{1'h1, 1'h0, 1'h0, 8'h01};
      cs_config[1] = '{1'h1, 1'h0, 1'h0, 8'h02};
      for (int k = 0; k < 5; k++) begin
         if (k == 3) cs_config[1].serial_clock_divider = 8'h01;
         cs_select = (k < 2) ? 2'h0 : 2'h1;
         write_word(16'h7E81);
         wait_xfer();
      end
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      conclude();
   end
endmodule
bind spi_errata_behaviour spi_errata_behaviour_asserts asserts_inst (.clk, .reset, .soft_reset_bit, .enable,
   .target_mode, .mode_fault_disable, .cs_select, .cs_config, .tx_write, .tx_empty_flag, .tx_lost_pulse,
   .sck, .busy);
